/* File: core/clk_synth_pkg.sv */
// Constants, types and register map of the DAC sample-clock synthesizer
// control block. Assumes one reference clock and a decoded register port.

package clk_synth_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_PWR_DN = 12'h011;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h01f;
  localparam logic [11:0] ADDR_IRQ_STS = 12'h023;
  localparam logic [11:0] ADDR_CH0_GAIN_HI = 12'h040;
  localparam logic [11:0] ADDR_CH0_GAIN_LO = 12'h041;
  localparam logic [11:0] ADDR_CH1_GAIN_HI = 12'h044;
  localparam logic [11:0] ADDR_CH1_GAIN_LO = 12'h045;
  localparam logic [11:0] ADDR_PLL_EN = 12'h083;
  localparam logic [11:0] ADDR_PLL_STS = 12'h084;
  localparam logic [11:0] ADDR_LOOP_DIV = 12'h085;
  localparam logic [11:0] ADDR_CP_CUR = 12'h08a;
  localparam logic [11:0] ADDR_OSC_DIV = 12'h08b;
  localparam logic [11:0] ADDR_REF_DIV = 12'h08c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EN_START_BIT = 4;
  localparam int EN_RECAL_BIT = 7;
  localparam int STS_UPPER_BIT = 7;
  localparam int STS_LOWER_BIT = 6;
  localparam int STS_CAL_DONE_BIT = 5;
  localparam int STS_LOCK_BIT = 1;
  localparam int IRQ_LOCK_BIT = 4;
  localparam int IRQ_LOST_BIT = 5;
  localparam int PD_CH0_BIT = 6;
  localparam int PD_CH1_BIT = 4;
  localparam int PD_BANDGAP_BIT = 7;
  localparam int PD_BIAS_BIT = 2;
  localparam int CP_BYPASS_BIT = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_LOOP_DIV = 8'h06;
  localparam logic [1:0] RST_OSC_DIV = 2'h1;
  localparam logic [2:0] RST_REF_DIV = 3'h0;

  // ****************************************
  // Calibration timing in reference cycles, search start codes and code offset
  // ****************************************
  localparam logic [6:0] CP_CAL_CYCLES = 7'h40;
  localparam logic [6:0] CP_CAL_LAST = CP_CAL_CYCLES - 7'h01;
  localparam logic [2:0] CP_STEP_LAST = 3'h7;
  localparam logic [5:0] CP_MSB = 6'h20;
  localparam logic [8:0] BAND_MSB = 9'h100;
  localparam logic [3:0] BAND_STEP_LAST = 4'hf;
  localparam logic [15:0] CODE_HALF = 16'h8000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CP_CAL = 3'h1,
    ST_BAND = 3'h3,
    ST_LOCK_WAIT = 3'h2,
    ST_RUN = 3'h6
  } synth_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic locked;
    logic band_upper;
    logic band_lower;
    logic cp_up_high;
    logic vco_fast;
  } analog_sts_t;

endpackage

/* File: core/channel_code_map.sv */
// One output channel: maps an input code to an unsigned output level.
// Assumes code, format and power-down come from the same clock domain.
`timescale 1ns/100ps

module channel_code_map (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_code,
  input wire logic i_twos,
  input wire logic i_power_down,
  output logic [15:0] o_level
);

  logic [15:0] level_ff;

  default clocking check_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Adding half the range to a twos complement code is an MSB flip
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      level_ff <= 16'h0000;
    end else if (i_power_down) begin
      level_ff <= 16'h0000;
    end else if (i_twos) begin
      level_ff <= i_code ^ clk_synth_pkg::CODE_HALF;
    end else begin
      level_ff <= i_code;
    end
  end

  assign o_level = level_ff;

  AST_TWOS_OFFSET: assert property (@(posedge i_clk)
    (!i_power_down && i_twos) |=>
      (o_level == ($past(i_code) ^ clk_synth_pkg::CODE_HALF)))
    else $error("twos complement code not offset by half range");

endmodule

/* File: core/dac_clk_synth_ctrl.sv */
// Control and status logic of the DAC sample-clock synthesizer.
// Runs on the reference clock; analog flags arrive unsynchronised.
`timescale 1ns/100ps

module dac_clk_synth_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire clk_synth_pkg::reg_req_t i_req,
  input wire clk_synth_pkg::analog_sts_t i_analog,
  input wire logic i_twos_complement,
  input wire logic [15:0] i_ch0_code,
  input wire logic [15:0] i_ch1_code,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_pll_enable,
  output logic [5:0] o_cp_current,
  output logic [5:0] o_cp_trim,
  output logic [8:0] o_vco_band,
  output logic [7:0] o_loop_divide_ratio,
  output logic [1:0] o_oscillator_divider_field,
  output logic [2:0] o_reference_divide_ratio,
  output logic [9:0] o_ch0_gain,
  output logic [9:0] o_ch1_gain,
  output logic o_ch0_power_down,
  output logic o_ch1_power_down,
  output logic o_bandgap_power_down,
  output logic o_bias_power_down,
  output logic [15:0] o_ch0_level,
  output logic [15:0] o_ch1_level
);

  // ****************************************
  // Declarations
  // ****************************************
  clk_synth_pkg::synth_state_t state_ff;
  clk_synth_pkg::synth_state_t nxt_state;
  clk_synth_pkg::analog_sts_t meta_ff;
  clk_synth_pkg::analog_sts_t sync_ff;
  logic [7:0] pwr_dn_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] irq_sts_ff;
  logic [7:0] pll_en_ff;
  logic [7:0] loop_div_ff;
  logic [7:0] cp_cur_ff;
  logic [1:0] osc_div_ff;
  logic [2:0] ref_div_ff;
  logic [9:0] gain0_ff;
  logic [9:0] gain1_ff;
  logic [6:0] cnt_ff;
  logic [5:0] cp_coef_ff;
  logic [5:0] cp_mask_ff;
  logic [8:0] band_ff;
  logic [8:0] band_mask_ff;
  logic cal_done_ff;
  logic lock_ff;
  logic upper_ff;
  logic lower_ff;
  logic recal_prev_ff;
  logic pll_on_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] nxt_rdata;
  logic active;
  logic recal_rise;
  logic cp_step;
  logic band_step;
  logic sts_w1c;

  default clocking check_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // Analog flag synchronisers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_analog;
      sync_ff <= meta_ff;
    end
  end

  // ****************************************
  // Host-written registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_dn_ff <= clk_synth_pkg::RST_REG;
      irq_en_ff <= clk_synth_pkg::RST_REG;
      pll_en_ff <= clk_synth_pkg::RST_REG;
      loop_div_ff <= clk_synth_pkg::RST_LOOP_DIV;
      cp_cur_ff <= clk_synth_pkg::RST_REG;
      osc_div_ff <= clk_synth_pkg::RST_OSC_DIV;
      ref_div_ff <= clk_synth_pkg::RST_REF_DIV;
      gain0_ff <= 10'h000;
      gain1_ff <= 10'h000;
    end else if (i_req.wr) begin
      case (i_req.addr)
        clk_synth_pkg::ADDR_PWR_DN: pwr_dn_ff <= i_req.wdata;
        clk_synth_pkg::ADDR_IRQ_EN: irq_en_ff <= i_req.wdata;
        clk_synth_pkg::ADDR_PLL_EN: pll_en_ff <= i_req.wdata;
        // Range 6..127 is the host's duty; stored as written
        clk_synth_pkg::ADDR_LOOP_DIV: loop_div_ff <= i_req.wdata;
        clk_synth_pkg::ADDR_CP_CUR: cp_cur_ff <= i_req.wdata;
        clk_synth_pkg::ADDR_OSC_DIV: begin
          // Code zero has no divide ratio; keep the old one
          if (i_req.wdata[1:0] != 2'h0) begin
            osc_div_ff <= i_req.wdata[1:0];
          end
        end
        clk_synth_pkg::ADDR_REF_DIV: ref_div_ff <= i_req.wdata[2:0];
        clk_synth_pkg::ADDR_CH0_GAIN_HI: begin
          gain0_ff[9:8] <= i_req.wdata[1:0];
        end
        clk_synth_pkg::ADDR_CH0_GAIN_LO: gain0_ff[7:0] <= i_req.wdata;
        clk_synth_pkg::ADDR_CH1_GAIN_HI: begin
          gain1_ff[9:8] <= i_req.wdata[1:0];
        end
        clk_synth_pkg::ADDR_CH1_GAIN_LO: gain1_ff[7:0] <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Calibration sequencer
  // ****************************************
  assign active = (state_ff == clk_synth_pkg::ST_LOCK_WAIT) ||
                  (state_ff == clk_synth_pkg::ST_RUN);
  assign recal_rise = pll_en_ff[clk_synth_pkg::EN_RECAL_BIT] && !recal_prev_ff;
  assign cp_step = (cnt_ff[2:0] == clk_synth_pkg::CP_STEP_LAST) &&
                   (cp_mask_ff != 6'h00);
  assign band_step = (cnt_ff[3:0] == clk_synth_pkg::BAND_STEP_LAST);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      clk_synth_pkg::ST_IDLE: begin
        if (pll_en_ff[clk_synth_pkg::EN_START_BIT]) begin
          // Coefficient kept from the first run, or pump bypassed; skip the pump
          if (cal_done_ff || cp_cur_ff[clk_synth_pkg::CP_BYPASS_BIT]) begin
            nxt_state = clk_synth_pkg::ST_BAND;
          end else begin
            nxt_state = clk_synth_pkg::ST_CP_CAL;
          end
        end
      end
      clk_synth_pkg::ST_CP_CAL: begin
        if (cnt_ff == clk_synth_pkg::CP_CAL_LAST) begin
          nxt_state = clk_synth_pkg::ST_BAND;
        end
      end
      clk_synth_pkg::ST_BAND: begin
        if (band_step && band_mask_ff == 9'h001) begin
          nxt_state = clk_synth_pkg::ST_LOCK_WAIT;
        end
      end
      clk_synth_pkg::ST_LOCK_WAIT: begin
        if (sync_ff.locked) begin
          nxt_state = clk_synth_pkg::ST_RUN;
        end else if (recal_rise) begin
          nxt_state = clk_synth_pkg::ST_BAND;
        end
      end
      clk_synth_pkg::ST_RUN: begin
        if (recal_rise) begin
          nxt_state = clk_synth_pkg::ST_BAND;
        end
      end
      default: nxt_state = clk_synth_pkg::ST_IDLE;
    endcase
    if (!pll_en_ff[clk_synth_pkg::EN_START_BIT]) begin
      nxt_state = clk_synth_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= clk_synth_pkg::ST_IDLE;
      recal_prev_ff <= 1'b0;
      pll_on_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      recal_prev_ff <= pll_en_ff[clk_synth_pkg::EN_RECAL_BIT];
      pll_on_ff <= (nxt_state != clk_synth_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || nxt_state != state_ff) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end

  // Successive approximation on the up/down current comparator
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cp_coef_ff <= 6'h00;
      cp_mask_ff <= 6'h00;
      cal_done_ff <= 1'b0;
    end else if (state_ff == clk_synth_pkg::ST_IDLE &&
                 nxt_state == clk_synth_pkg::ST_CP_CAL) begin
      cp_coef_ff <= clk_synth_pkg::CP_MSB;
      cp_mask_ff <= clk_synth_pkg::CP_MSB;
    end else if (state_ff == clk_synth_pkg::ST_CP_CAL) begin
      if (cp_step) begin
        cp_coef_ff <= (sync_ff.cp_up_high ? (cp_coef_ff & ~cp_mask_ff)
                                          : cp_coef_ff) | (cp_mask_ff >> 1);
        cp_mask_ff <= cp_mask_ff >> 1;
      end
      if (cnt_ff == clk_synth_pkg::CP_CAL_LAST) begin
        cal_done_ff <= 1'b1;
      end
    end
  end

  // Binary search over the oscillator bands
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      band_ff <= clk_synth_pkg::BAND_MSB;
      band_mask_ff <= clk_synth_pkg::BAND_MSB;
    end else if (nxt_state == clk_synth_pkg::ST_BAND &&
                 state_ff != clk_synth_pkg::ST_BAND) begin
      band_ff <= clk_synth_pkg::BAND_MSB;
      band_mask_ff <= clk_synth_pkg::BAND_MSB;
    end else if (state_ff == clk_synth_pkg::ST_BAND && band_step) begin
      band_ff <= (sync_ff.vco_fast ? (band_ff & ~band_mask_ff) : band_ff) |
                 (band_mask_ff >> 1);
      band_mask_ff <= band_mask_ff >> 1;
    end
  end

  // ****************************************
  // Status flags and lock events
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lock_ff <= 1'b0;
      upper_ff <= 1'b0;
      lower_ff <= 1'b0;
    end else begin
      lock_ff <= sync_ff.locked && active;
      upper_ff <= sync_ff.band_upper && active;
      lower_ff <= sync_ff.band_lower && active;
    end
  end

  assign sts_w1c = i_req.wr && (i_req.addr == clk_synth_pkg::ADDR_IRQ_STS);

  // New event beats a write-one-to-clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_sts_ff <= 8'h00;
    end else begin
      irq_sts_ff[clk_synth_pkg::IRQ_LOCK_BIT] <=
        (irq_en_ff[clk_synth_pkg::IRQ_LOCK_BIT] && sync_ff.locked &&
         active && !lock_ff) ||
        (irq_sts_ff[clk_synth_pkg::IRQ_LOCK_BIT] &&
         !(sts_w1c && i_req.wdata[clk_synth_pkg::IRQ_LOCK_BIT]));
      irq_sts_ff[clk_synth_pkg::IRQ_LOST_BIT] <=
        (irq_en_ff[clk_synth_pkg::IRQ_LOST_BIT] && lock_ff &&
         !(sync_ff.locked && active)) ||
        (irq_sts_ff[clk_synth_pkg::IRQ_LOST_BIT] &&
         !(sts_w1c && i_req.wdata[clk_synth_pkg::IRQ_LOST_BIT]));
    end
  end

  // ****************************************
  // Read-back
  // ****************************************
  always_comb begin
    nxt_rdata = 8'h00;
    case (i_req.addr)
      clk_synth_pkg::ADDR_PWR_DN: nxt_rdata = pwr_dn_ff;
      clk_synth_pkg::ADDR_IRQ_EN: nxt_rdata = irq_en_ff;
      clk_synth_pkg::ADDR_IRQ_STS: nxt_rdata = irq_sts_ff;
      clk_synth_pkg::ADDR_CH0_GAIN_HI: nxt_rdata = {6'h00, gain0_ff[9:8]};
      clk_synth_pkg::ADDR_CH0_GAIN_LO: nxt_rdata = gain0_ff[7:0];
      clk_synth_pkg::ADDR_CH1_GAIN_HI: nxt_rdata = {6'h00, gain1_ff[9:8]};
      clk_synth_pkg::ADDR_CH1_GAIN_LO: nxt_rdata = gain1_ff[7:0];
      clk_synth_pkg::ADDR_PLL_EN: nxt_rdata = pll_en_ff;
      clk_synth_pkg::ADDR_PLL_STS: begin
        nxt_rdata[clk_synth_pkg::STS_UPPER_BIT] = upper_ff;
        nxt_rdata[clk_synth_pkg::STS_LOWER_BIT] = lower_ff;
        nxt_rdata[clk_synth_pkg::STS_CAL_DONE_BIT] = cal_done_ff;
        nxt_rdata[clk_synth_pkg::STS_LOCK_BIT] = lock_ff;
      end
      clk_synth_pkg::ADDR_LOOP_DIV: nxt_rdata = loop_div_ff;
      clk_synth_pkg::ADDR_CP_CUR: nxt_rdata = cp_cur_ff;
      clk_synth_pkg::ADDR_OSC_DIV: nxt_rdata = {6'h00, osc_div_ff};
      clk_synth_pkg::ADDR_REF_DIV: nxt_rdata = {5'h00, ref_div_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= i_req.rd ? nxt_rdata : 8'h00;
      rvalid_ff <= i_req.rd;
    end
  end

  // ****************************************
  // Channels and outputs
  // ****************************************
  channel_code_map u_ch0 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_code(i_ch0_code),
    .i_twos(i_twos_complement),
    .i_power_down(pwr_dn_ff[clk_synth_pkg::PD_CH0_BIT]),
    .o_level(o_ch0_level)
  );

  channel_code_map u_ch1 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_code(i_ch1_code),
    .i_twos(i_twos_complement),
    .i_power_down(pwr_dn_ff[clk_synth_pkg::PD_CH1_BIT]),
    .o_level(o_ch1_level)
  );

  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_pll_enable = pll_on_ff;
  assign o_cp_current = cp_cur_ff[5:0];
  assign o_cp_trim = cp_coef_ff;
  assign o_vco_band = band_ff;
  assign o_loop_divide_ratio = loop_div_ff;
  assign o_oscillator_divider_field = osc_div_ff;
  assign o_reference_divide_ratio = ref_div_ff;
  assign o_ch0_gain = gain0_ff;
  assign o_ch1_gain = gain1_ff;
  assign o_ch0_power_down = pwr_dn_ff[clk_synth_pkg::PD_CH0_BIT];
  assign o_ch1_power_down = pwr_dn_ff[clk_synth_pkg::PD_CH1_BIT];
  assign o_bandgap_power_down = pwr_dn_ff[clk_synth_pkg::PD_BANDGAP_BIT];
  assign o_bias_power_down = pwr_dn_ff[clk_synth_pkg::PD_BIAS_BIT];

  // ****************************************
  // Checks
  // ****************************************
  AST_CP_CAL_BOUND: assert property (@(posedge i_clk)
    (state_ff == clk_synth_pkg::ST_CP_CAL &&
     $past(state_ff) != clk_synth_pkg::ST_CP_CAL) |->
      ##[1:64] (state_ff != clk_synth_pkg::ST_CP_CAL))
    else $error("pump calibration ran past 64 cycles");

  AST_CAL_KEPT: assert property (@(posedge i_clk)
    cal_done_ff |=> (cal_done_ff && state_ff != clk_synth_pkg::ST_CP_CAL))
    else $error("pump calibration repeated or result lost");

  AST_START: assert property (@(posedge i_clk)
    (state_ff == clk_synth_pkg::ST_IDLE &&
     pll_en_ff[clk_synth_pkg::EN_START_BIT]) |=> ##1 o_pll_enable)
    else $error("enable bit did not start the synthesizer");

  AST_BAND_SEARCH: assert property (@(posedge i_clk)
    $rose(state_ff == clk_synth_pkg::ST_BAND) |->
      ##[144:145] (state_ff != clk_synth_pkg::ST_BAND))
    else $error("band search length wrong");

  AST_LOCK_READ: assert property (@(posedge i_clk)
    (i_req.rd && i_req.addr == clk_synth_pkg::ADDR_PLL_STS) |=>
      (o_rdata[clk_synth_pkg::STS_LOCK_BIT] == $past(lock_ff) &&
       o_rdata[clk_synth_pkg::STS_CAL_DONE_BIT] == $past(cal_done_ff)))
    else $error("status read does not match lock or done state");

  AST_IRQ_LOCK_SET: assert property (@(posedge i_clk)
    ($rose(lock_ff) && irq_en_ff[clk_synth_pkg::IRQ_LOCK_BIT] &&
     $past(irq_en_ff[clk_synth_pkg::IRQ_LOCK_BIT])) |->
      irq_sts_ff[clk_synth_pkg::IRQ_LOCK_BIT])
    else $error("lock event not recorded");

  AST_IRQ_HOLD: assert property (@(posedge i_clk)
    (irq_sts_ff[clk_synth_pkg::IRQ_LOST_BIT] &&
     !(sts_w1c && i_req.wdata[clk_synth_pkg::IRQ_LOST_BIT])) |=>
      irq_sts_ff[clk_synth_pkg::IRQ_LOST_BIT])
    else $error("lost-lock status cleared without write");

  AST_OSC_DIV_LEGAL: assert property (@(posedge i_clk)
    osc_div_ff != 2'h0)
    else $error("oscillator divider field took code zero");

  AST_GAIN_LOW: assert property (@(posedge i_clk)
    (i_req.wr && i_req.addr == clk_synth_pkg::ADDR_CH1_GAIN_LO) |=>
      (o_ch1_gain[7:0] == $past(i_req.wdata)))
    else $error("channel 1 gain low byte not stored");

  AST_PD_CH0: assert property (@(posedge i_clk)
    o_ch0_power_down |=> (o_ch0_level == 16'h0000))
    else $error("powered-down channel 0 still drives a level");

endmodule

/* File: dv/dac_clk_synth_ctrl_tb_top.sv */
// Self-checking bench for the synthesizer control block.
// Assumes the block alone, register port and analog flags driven here.
`timescale 1ns/100ps

module dac_clk_synth_ctrl_tb_top;
  logic i_clk;
  logic i_rst_n;
  clk_synth_pkg::reg_req_t req;
  clk_synth_pkg::analog_sts_t ana;
  logic twos;
  logic [15:0] code0;
  logic [15:0] code1;
  logic [7:0] rdata;
  logic rvalid;
  logic pll_en;
  logic [5:0] cp_cur;
  logic [5:0] cp_trim;
  logic [8:0] band;
  logic [7:0] loop_div;
  logic [1:0] osc_div;
  logic [2:0] ref_div;
  logic [9:0] gain0;
  logic [9:0] gain1;
  logic pd0;
  logic pd1;
  logic pd_bg;
  logic pd_bias;
  logic [15:0] lvl0;
  logic [15:0] lvl1;
  int fail_count;
  int samples_checked;

  dac_clk_synth_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_analog(ana), .i_twos_complement(twos), .i_ch0_code(code0),
    .i_ch1_code(code1), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_pll_enable(pll_en), .o_cp_current(cp_cur), .o_cp_trim(cp_trim),
    .o_vco_band(band), .o_loop_divide_ratio(loop_div),
    .o_oscillator_divider_field(osc_div), .o_reference_divide_ratio(ref_div),
    .o_ch0_gain(gain0), .o_ch1_gain(gain1), .o_ch0_power_down(pd0),
    .o_ch1_power_down(pd1), .o_bandgap_power_down(pd_bg),
    .o_bias_power_down(pd_bias), .o_ch0_level(lvl0), .o_ch1_level(lvl1));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ****************************************
  // Checks and register access
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Inputs move 1 ns after the edge so the sampling edge sees them settled
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    req.rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    d = rdata;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    int n;
    fail_count = 0;
    samples_checked = 0;
    i_rst_n = 1'b0;
    req = '0;
    ana = '0;
    twos = 1'b0;
    code0 = 16'h0000;
    code1 = 16'h0000;
    cyc(20);
    i_rst_n = 1'b1;
    rd_chk(12'h083, 8'h00);
    rd_chk(12'h084, 8'h00);
    chk("loop_div", 16'h0006, {8'h00, loop_div});
    chk("osc_div", 16'h0001, {14'h0000, osc_div});
    chk("band", 16'h0100, {7'h00, band});
    wr(12'h08a, 8'h2a);
    chk("cp_cur", 16'h002a, {10'h000, cp_cur});
    rd_chk(12'h08a, 8'h2a);
    wr(12'h08b, 8'h00);
    chk("osc_div", 16'h0001, {14'h0000, osc_div});
    wr(12'h08b, 8'h03);
    chk("osc_div", 16'h0003, {14'h0000, osc_div});
    wr(12'h085, 8'h10);
    wr(12'h08c, 8'h03);
    chk("ref_div", 16'h0003, {13'h0000, ref_div});
    chk("loop_div", 16'h0010, {8'h00, loop_div});
    wr(12'h1b5, 8'h09);
    wr(12'h1bb, 8'h03);
    wr(12'h1c5, 8'h06);
    rd_chk(12'h1b5, 8'h00);
    wr(12'h040, 8'h03);
    wr(12'h041, 8'h5a);
    wr(12'h044, 8'h02);
    wr(12'h045, 8'ha5);
    chk("gain0", 16'h035a, {6'h00, gain0});
    chk("gain1", 16'h02a5, {6'h00, gain1});
    rd_chk(12'h041, 8'h5a);
    code0 = 16'hffff;
    code1 = 16'h1234;
    cyc(4);
    chk("lvl0", 16'hffff, lvl0);
    chk("lvl1", 16'h1234, lvl1);
    twos = 1'b1;
    cyc(4);
    chk("lvl0", 16'h7fff, lvl0);
    chk("lvl1", 16'h9234, lvl1);
    // Reference and bias bits stay low as the host must keep them
    wr(12'h011, 8'h50);
    cyc(4);
    chk("pd", 16'h0006, {12'h000, pd_bg, pd0, pd1, pd_bias});
    chk("lvl0", 16'h0000, lvl0);
    chk("lvl1", 16'h0000, lvl1);
    rd_chk(12'h011, 8'h50);
    wr(12'h011, 8'h00);
    wr(12'h01f, 8'h30);
    wr(12'h083, 8'h10);
    cyc(2);
    chk("pll_en", 16'h0001, {15'h0000, pll_en});
    rd_chk(12'h084, 8'h00);
    n = 0;
    d = 8'h00;
    // Bound leaves a few cycles of read latency over the 64-cycle limit
    while (d[5] !== 1'b1 && n < 33) begin
      rd(12'h084, d);
      n++;
    end
    chk("cal_in_time", 16'h0001, {15'h0000, d[5]});
    if (d[5] !== 1'b1) tally_and_finish();
    chk("cp_trim", 16'h003f, {10'h000, cp_trim});
    cyc(160);
    chk("band", 16'h01ff, {7'h00, band});
    ana.locked = 1'b1;
    cyc(6);
    rd_chk(12'h084, 8'h22);
    rd_chk(12'h023, 8'h10);
    ana.band_upper = 1'b1;
    cyc(6);
    rd_chk(12'h084, 8'ha2);
    ana.band_upper = 1'b0;
    ana.band_lower = 1'b1;
    cyc(6);
    rd_chk(12'h084, 8'h62);
    ana.band_lower = 1'b0;
    wr(12'h084, 8'h00);
    cyc(6);
    rd_chk(12'h084, 8'h22);
    ana.locked = 1'b0;
    cyc(6);
    rd_chk(12'h084, 8'h20);
    rd_chk(12'h023, 8'h30);
    rd_chk(12'h023, 8'h30);
    wr(12'h023, 8'h10);
    rd_chk(12'h023, 8'h20);
    // Recalibration with a fast oscillator drives every band bit low
    ana.vco_fast = 1'b1;
    wr(12'h083, 8'h90);
    cyc(160);
    chk("band", 16'h0000, {7'h00, band});
    wr(12'h083, 8'h00);
    cyc(2);
    chk("pll_en", 16'h0000, {15'h0000, pll_en});
    ana.cp_up_high = 1'b1;
    wr(12'h083, 8'h10);
    cyc(80);
    chk("cp_trim", 16'h003f, {10'h000, cp_trim});
    rd_chk(12'h084, 8'h20);
    // Reset in mid-search, then a start with pump calibration bypassed
    i_rst_n = 1'b0;
    cyc(3);
    i_rst_n = 1'b1;
    chk("band", 16'h0100, {7'h00, band});
    chk("cp_trim", 16'h0000, {10'h000, cp_trim});
    wr(12'h08a, 8'h80);
    wr(12'h083, 8'h10);
    cyc(150);
    chk("band", 16'h0000, {7'h00, band});
    chk("cp_trim", 16'h0000, {10'h000, cp_trim});
    rd_chk(12'h084, 8'h00);
    tally_and_finish();
  end
endmodule
